// ==== mft_pkg.sv ====
// Constants shared by the timer output-B/flag/DMA block and its controller end.
// Assumes both ends compile against this package first.
package mft_pkg;

   // Device register addresses on the link
   localparam logic [7:0] MFT_ADDR_PTR = 8'hf0;
   localparam logic [7:0] MFT_ADDR_OUTB = 8'hfd;
   localparam logic [7:0] MFT_ADDR_FLAGS = 8'hfe;
   localparam logic [7:0] MFT_ADDR_MASK = 8'hff;

   // Reset values
   localparam logic [7:0] MFT_OUTB_RST = 8'h00;
   localparam logic [7:0] MFT_FLAGS_RST = 8'h00;
   localparam logic [7:0] MFT_MASK_RST = 8'h00;
   localparam logic [7:0] MFT_PTR_RST = 8'h00;

   // Output B action control fields
   localparam int MFT_OB_C0_HI = 7;
   localparam int MFT_OB_C0_LO = 6;
   localparam int MFT_OB_C1_HI = 5;
   localparam int MFT_OB_C1_LO = 4;
   localparam int MFT_OB_WR_HI = 3;
   localparam int MFT_OB_WR_LO = 2;
   localparam int MFT_OB_OEV = 1;
   localparam int MFT_OB_LEVEL = 0;

   // Event flag bits
   localparam int MFT_FL_CP0 = 7;
   localparam int MFT_FL_CP1 = 6;
   localparam int MFT_FL_CM0 = 5;
   localparam int MFT_FL_CM1 = 4;
   localparam int MFT_FL_WRAP = 3;
   localparam int MFT_FL_CAPTURE0_OVERRUN_FLAG = 2;
   localparam int MFT_FL_COMPARE0_OVERRUN_FLAG = 1;
   localparam int MFT_FL_AND = 0;

   // Interrupt/DMA mask bits
   localparam int MFT_MK_GT = 7;
   localparam int MFT_MK_CAPTURE0_DMA_ENABLE = 6;
   localparam int MFT_MK_CAPTURE0_INT_MASK = 5;
   localparam int MFT_MK_CAPTURE1_INT_MASK = 4;
   localparam int MFT_MK_COMPARE0_DMA_ENABLE = 3;
   localparam int MFT_MK_COMPARE0_INT_MASK = 2;
   localparam int MFT_MK_COMPARE1_INT_MASK = 1;
   localparam int MFT_MK_WRI = 0;

   // DMA counter pointer bits
   localparam int MFT_PT_SWAP = 2;
   localparam int MFT_PT_DIR = 1;
   localparam int MFT_PT_AREA = 0;

   // Output actions
   localparam logic [1:0] MFT_ACT_SET = 2'b00;
   localparam logic [1:0] MFT_ACT_TOGGLE = 2'b01;
   localparam logic [1:0] MFT_ACT_RESET = 2'b10;
   localparam logic [1:0] MFT_ACT_NOP = 2'b11;

   // Controller APB map (byte addresses)
   localparam logic [11:0] MFT_APB_CAP_LEN = 12'h000;
   localparam logic [11:0] MFT_APB_CMP_LEN = 12'h004;
   localparam logic [11:0] MFT_APB_CTRL = 12'h008;
   localparam logic [11:0] MFT_APB_STATUS = 12'h00c;
   localparam int MFT_APB_WIN_BIT = 10;
   localparam logic [7:0] MFT_LEN_RST = 8'h01;

endpackage

// ==== mft_link_if.sv ====
// Link between the timer block and its DMA/interrupt controller end.
// Assumes both ends share one clock; all signals are synchronous to it.
`timescale 1ns/1ns
`default_nettype none
interface mft_link_if;
   // Register access
   logic reg_sel;
   logic reg_wr;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   // Interrupt groups
   logic int_capture;
   logic int_compare;
   logic int_wrap;
   // DMA
   logic dma_cap_req;
   logic dma_cmp_req;
   logic [7:0] dma_ptr;
   logic eob_cap;
   logic eob_cmp;
   logic swap_toggle;

   modport dev_mp (
      input reg_sel, reg_wr, reg_addr, reg_wdata, eob_cap, eob_cmp, swap_toggle,
      output reg_rdata, int_capture, int_compare, int_wrap, dma_cap_req, dma_cmp_req,
      output dma_ptr
   );
   modport host_mp (
      output reg_sel, reg_wr, reg_addr, reg_wdata, eob_cap, eob_cmp, swap_toggle,
      input reg_rdata, int_capture, int_compare, int_wrap, dma_cap_req, dma_cmp_req,
      input dma_ptr
   );
endinterface
`default_nettype wire

// ==== mft_outb_flags_dma_ctrl.sv ====
// Timer output-B action control, event flags, interrupt/DMA mask, DMA pointer.
// Assumes event inputs are one-cycle pulses from the counter/compare logic.
//
// Functional notes
// - Compare events drive output B by field
// - Wrap event drives output B by field
// - Simultaneous events: AND of action codes
// - Wrap pulses on-chip event when enabled
// - Preset bit writes level, reads pin
// - Capture 0 flag; write 1 emulates capture
// - Capture 1 flag; emulate unless bicapture
// - Capture interrupt OR or AND select
// - Compare 0 flag, gated interrupt
// - Compare 1 flag, gated interrupt
// - Wrap flag, gated interrupt
// - Capture 0 overrun, also on emulation
// - Compare 0 overrun, software clears
// - Global enable gates every interrupt
// - Capture DMA enable cleared at block end
// - Capture 0 mask enables end-of-block when DMA
// - Compare DMA enable cleared at block end
// - Compare 0 mask enables end-of-block when DMA
// - Masks for capture 1, compare 1, wrap
// - Pointer high bits; swap toggles lowest
// - Direction bit follows DMA source
// - Area bit selects memory or register file
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module mft_outb_flags_dma_ctrl
   import mft_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Controller link
   mft_link_if.dev_mp link,
   // Timer events
   input wire logic cmp0_match_in,
   input wire logic cmp1_match_in,
   input wire logic cap0_event_in,
   input wire logic cap1_event_in,
   input wire logic wrap_event_in,
   input wire logic bicapture_mode_in,
   // Outputs to pin and timer core
   output logic timer_output_two_out,
   output logic onchip_event_out,
   output logic sw_capture0_out,
   output logic sw_capture1_out
);

   logic [7:1] outb_ctrl;
   logic outb_level;
   logic [7:0] flags;
   logic [7:0] mask;
   logic [7:0] ptr;
   logic cap_eob_pend;
   logic cmp_eob_pend;
   logic dma_cap_q;
   logic dma_cmp_q;

   // Action code of one event, NOP when the event is absent
   function automatic logic [1:0] act_of(input logic ev, input logic [1:0] code);
      act_of = ev ? code : MFT_ACT_NOP;
   endfunction

   // New pin level from action code
   function automatic logic apply_act(input logic [1:0] act, input logic cur);
      case (act)
         MFT_ACT_SET: apply_act = 1'b1;
         MFT_ACT_TOGGLE: apply_act = ~cur;
         MFT_ACT_RESET: apply_act = 1'b0;
         default: apply_act = cur;
      endcase
   endfunction

   // Register decode
   wire wr_en = link.reg_sel & link.reg_wr;
   wire wr_outb = wr_en & (link.reg_addr == MFT_ADDR_OUTB);
   wire wr_flags = wr_en & (link.reg_addr == MFT_ADDR_FLAGS);
   wire wr_mask = wr_en & (link.reg_addr == MFT_ADDR_MASK);
   wire wr_ptr = wr_en & (link.reg_addr == MFT_ADDR_PTR);
   wire [7:0] wd = link.reg_wdata;

   // Output B action
   wire [1:0] act_c0 = act_of(cmp0_match_in, outb_ctrl[MFT_OB_C0_HI:MFT_OB_C0_LO]);
   wire [1:0] act_c1 = act_of(cmp1_match_in, outb_ctrl[MFT_OB_C1_HI:MFT_OB_C1_LO]);
   wire [1:0] act_wr = act_of(wrap_event_in, outb_ctrl[MFT_OB_WR_HI:MFT_OB_WR_LO]);
   wire [1:0] act_all = act_c0 & act_c1 & act_wr;
   wire any_out_ev = cmp0_match_in | cmp1_match_in | wrap_event_in;
   // Hardware event wins over a same-cycle preset write
   wire next_level = any_out_ev ? apply_act(act_all, outb_level) :
                     wr_outb ? wd[MFT_OB_LEVEL] : outb_level;

   // Software capture emulation
   wire sw_cp0 = wr_flags & wd[MFT_FL_CP0];
   wire sw_cp1 = wr_flags & wd[MFT_FL_CP1] & ~bicapture_mode_in;

   // Hardware flag sets; set wins over a clearing write
   wire [7:0] flag_set;
   assign flag_set[MFT_FL_CP0] = cap0_event_in | sw_cp0;
   assign flag_set[MFT_FL_CP1] = cap1_event_in | sw_cp1;
   assign flag_set[MFT_FL_CM0] = cmp0_match_in;
   assign flag_set[MFT_FL_CM1] = cmp1_match_in;
   assign flag_set[MFT_FL_WRAP] = wrap_event_in;
   assign flag_set[MFT_FL_CAPTURE0_OVERRUN_FLAG] = (cap0_event_in & flags[MFT_FL_CP0]) | sw_cp0;
   assign flag_set[MFT_FL_COMPARE0_OVERRUN_FLAG] = cmp0_match_in & flags[MFT_FL_CM0];
   assign flag_set[MFT_FL_AND] = 1'b0;
   wire [7:0] next_flags = (wr_flags ? wd : flags) | flag_set;

   // Mask: DMA enables cleared by hardware at block end
   wire [7:0] mask_clr = {1'b0, link.eob_cap, 2'b00, link.eob_cmp, 3'b000};
   wire [7:0] next_mask = (wr_mask ? wd : mask) & ~mask_clr;

   // End-of-block pending; set wins over re-arm write
   wire next_cap_eob = link.eob_cap |
                       (cap_eob_pend & ~(wr_mask & wd[MFT_MK_CAPTURE0_DMA_ENABLE]));
   wire next_cmp_eob = link.eob_cmp |
                       (cmp_eob_pend & ~(wr_mask & wd[MFT_MK_COMPARE0_DMA_ENABLE]));

   // DMA pointer: software bits plus swap toggle
   wire [7:0] ptr_base = wr_ptr ? {wd[7:2], ptr[MFT_PT_DIR], wd[MFT_PT_AREA]} : ptr;
   wire [7:0] ptr_tog = {5'b00000, link.swap_toggle, 2'b00};
   wire next_dma_cap = cap0_event_in & mask[MFT_MK_CAPTURE0_DMA_ENABLE];
   wire next_dma_cmp = cmp0_match_in & mask[MFT_MK_COMPARE0_DMA_ENABLE];
   wire next_dir = next_dma_cmp ? 1'b1 : next_dma_cap ? 1'b0 : ptr[MFT_PT_DIR];
   wire [7:0] next_ptr_raw = ptr_base ^ ptr_tog;
   wire [7:0] next_ptr = {next_ptr_raw[7:2], next_dir, next_ptr_raw[MFT_PT_AREA]};

   // Interrupt sources
   wire gt_en = mask[MFT_MK_GT];
   wire cap0_src = mask[MFT_MK_CAPTURE0_DMA_ENABLE] ? cap_eob_pend : flags[MFT_FL_CP0];
   wire cap0_on = cap0_src & mask[MFT_MK_CAPTURE0_INT_MASK];
   wire cap1_on = flags[MFT_FL_CP1] & mask[MFT_MK_CAPTURE1_INT_MASK];
   wire cap_and = cap0_on & flags[MFT_FL_CP1];
   wire cap_grp = flags[MFT_FL_AND] ? cap_and : (cap0_on | cap1_on);
   wire cmp0_src = mask[MFT_MK_COMPARE0_DMA_ENABLE] ? cmp_eob_pend : flags[MFT_FL_CM0];
   wire cmp0_on = cmp0_src & mask[MFT_MK_COMPARE0_INT_MASK];
   wire cmp1_on = flags[MFT_FL_CM1] & mask[MFT_MK_COMPARE1_INT_MASK];
   wire wrap_on = flags[MFT_FL_WRAP] & mask[MFT_MK_WRI];

   assign link.int_capture = gt_en & cap_grp;
   assign link.int_compare = gt_en & (cmp0_on | cmp1_on);
   assign link.int_wrap = gt_en & wrap_on;
   assign link.dma_cap_req = dma_cap_q;
   assign link.dma_cmp_req = dma_cmp_q;
   assign link.dma_ptr = ptr;

   // Read mux; preset bit reads the live pin level
   wire [7:0] rd_outb = {outb_ctrl, outb_level};
   assign link.reg_rdata = (link.reg_addr == MFT_ADDR_OUTB) ? rd_outb :
                           (link.reg_addr == MFT_ADDR_FLAGS) ? flags :
                           (link.reg_addr == MFT_ADDR_MASK) ? mask :
                           (link.reg_addr == MFT_ADDR_PTR) ? ptr : 8'h00;

   assign timer_output_two_out = outb_level;

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         outb_ctrl <= MFT_OUTB_RST[7:1];
         outb_level <= MFT_OUTB_RST[MFT_OB_LEVEL];
      end else begin
         if (wr_outb) begin
            outb_ctrl <= wd[7:1];
         end
         outb_level <= next_level;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         flags <= MFT_FLAGS_RST;
         mask <= MFT_MASK_RST;
         ptr <= MFT_PTR_RST;
         cap_eob_pend <= 1'b0;
         cmp_eob_pend <= 1'b0;
      end else begin
         flags <= next_flags;
         mask <= next_mask;
         ptr <= next_ptr;
         cap_eob_pend <= next_cap_eob;
         cmp_eob_pend <= next_cmp_eob;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         dma_cap_q <= 1'b0;
         dma_cmp_q <= 1'b0;
         onchip_event_out <= 1'b0;
         sw_capture0_out <= 1'b0;
         sw_capture1_out <= 1'b0;
      end else begin
         dma_cap_q <= next_dma_cap;
         dma_cmp_q <= next_dma_cmp;
         onchip_event_out <= wrap_event_in & outb_ctrl[MFT_OB_OEV];
         sw_capture0_out <= sw_cp0;
         sw_capture1_out <= sw_cp1;
      end
   end

endmodule
`default_nettype wire

// ==== mft_dma_int_host.sv ====
// Controller end: APB slave, register window onto the timer, DMA block counters.
// Assumes the timer end shares ref_clk_in; APB master follows the usual handshake.
`timescale 1ns/1ns
`default_nettype none
module mft_dma_int_host
   import mft_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Interrupt to the core
   output logic irq_out,
   // Timer link
   mft_link_if.host_mp link
);

   logic pend;
   logic [7:0] cap_len;
   logic [7:0] cmp_len;
   logic [7:0] cap_left;
   logic [7:0] cmp_left;
   logic swap_en;
   logic eob_cap_q;
   logic eob_cmp_q;
   logic swap_q;

   // APB decode; answer in the second access cycle
   wire access = psel_in & penable_in;
   wire in_win = paddr_in[MFT_APB_WIN_BIT];
   wire commit = access & pend & pwrite_in;
   wire wr_cap_len = commit & ~in_win & (paddr_in == MFT_APB_CAP_LEN);
   wire wr_cmp_len = commit & ~in_win & (paddr_in == MFT_APB_CMP_LEN);
   wire wr_ctrl = commit & ~in_win & (paddr_in == MFT_APB_CTRL);

   assign link.reg_sel = access & in_win;
   assign link.reg_wr = pwrite_in & pend;
   assign link.reg_addr = paddr_in[9:2];
   assign link.reg_wdata = pwdata_in[7:0];
   assign link.eob_cap = eob_cap_q;
   assign link.eob_cmp = eob_cmp_q;
   assign link.swap_toggle = swap_q;
   assign pready_out = pend;
   assign pslverr_out = 1'b0;

   wire [31:0] status = {13'h0000, link.int_wrap, link.int_compare, link.int_capture,
                         cmp_left, cap_left};
   wire [31:0] own_rd = (paddr_in == MFT_APB_CAP_LEN) ? {24'h00_0000, cap_len} :
                        (paddr_in == MFT_APB_CMP_LEN) ? {24'h00_0000, cmp_len} :
                        (paddr_in == MFT_APB_CTRL) ? {31'h0000_0000, swap_en} :
                        (paddr_in == MFT_APB_STATUS) ? status : 32'h0000_0000;
   wire [31:0] rd_val = in_win ? {24'h00_0000, link.reg_rdata} : own_rd;

   // Block counters: last transfer ends the block and reloads
   wire cap_last = link.dma_cap_req & (cap_left <= 8'h01);
   wire cmp_last = link.dma_cmp_req & (cmp_left <= 8'h01);
   wire [7:0] next_cap_left = wr_cap_len ? pwdata_in[7:0] :
                              cap_last ? cap_len :
                              link.dma_cap_req ? cap_left - 8'h01 : cap_left;
   wire [7:0] next_cmp_left = wr_cmp_len ? pwdata_in[7:0] :
                              cmp_last ? cmp_len :
                              link.dma_cmp_req ? cmp_left - 8'h01 : cmp_left;

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         pend <= 1'b0;
         prdata_out <= 32'h0000_0000;
         irq_out <= 1'b0;
      end else begin
         pend <= access & ~pend;
         if (access & ~pend & ~pwrite_in) begin
            prdata_out <= rd_val;
         end
         irq_out <= link.int_capture | link.int_compare | link.int_wrap;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         cap_len <= MFT_LEN_RST;
         cmp_len <= MFT_LEN_RST;
         cap_left <= MFT_LEN_RST;
         cmp_left <= MFT_LEN_RST;
         swap_en <= 1'b0;
         eob_cap_q <= 1'b0;
         eob_cmp_q <= 1'b0;
         swap_q <= 1'b0;
      end else begin
         if (wr_cap_len) begin
            cap_len <= pwdata_in[7:0];
         end
         if (wr_cmp_len) begin
            cmp_len <= pwdata_in[7:0];
         end
         if (wr_ctrl) begin
            swap_en <= pwdata_in[0];
         end
         cap_left <= next_cap_left;
         cmp_left <= next_cmp_left;
         eob_cap_q <= cap_last;
         eob_cmp_q <= cmp_last;
         swap_q <= cmp_last & swap_en;
      end
   end

endmodule
`default_nettype wire

// ==== mft_link_monitor.sv ====
// Checker on the link between the timer block and its controller end.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module mft_link_monitor
   import mft_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Link signals
   input wire logic reg_sel,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic int_capture,
   input wire logic int_compare,
   input wire logic int_wrap,
   input wire logic dma_cap_req,
   input wire logic dma_cmp_req,
   input wire logic [7:0] dma_ptr,
   input wire logic eob_cap,
   input wire logic eob_cmp,
   input wire logic swap_toggle
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   wire logic mask_rd = (reg_addr == MFT_ADDR_MASK);
   wire logic outb_wr = reg_sel && reg_wr && (reg_addr == MFT_ADDR_OUTB);

   a_global_gate: assert property (mask_rd && !reg_rdata[MFT_MK_GT] |->
      !(int_capture || int_compare || int_wrap)) else $error("interrupt while globally off");
   a_wrap_mask: assert property (mask_rd && !reg_rdata[MFT_MK_WRI] |-> !int_wrap)
      else $error("wrap interrupt while masked");
   a_cmp_masks: assert property (mask_rd && !reg_rdata[MFT_MK_COMPARE0_INT_MASK] &&
      !reg_rdata[MFT_MK_COMPARE1_INT_MASK] |-> !int_compare) else $error("compare interrupt while masked");
   a_cmp_dir_set: assert property (dma_cmp_req |-> ##[0:1] dma_ptr[MFT_PT_DIR])
      else $error("direction not set on compare request");
   a_cap_dir_clr: assert property (dma_cap_req && !dma_cmp_req |->
      ##[0:1] !dma_ptr[MFT_PT_DIR]) else $error("direction not cleared on capture request");
   a_swap_with_eob: assert property (swap_toggle |-> eob_cmp)
      else $error("swap toggle without block end");
   a_swap_flips_bit: assert property (swap_toggle |=>
      dma_ptr[MFT_PT_SWAP] != $past(dma_ptr[MFT_PT_SWAP])) else $error("swap bit not toggled");
   a_cap_eob_order: assert property (eob_cap |-> $past(dma_cap_req))
      else $error("capture block end without request");
   a_cmp_eob_order: assert property (eob_cmp |-> $past(dma_cmp_req))
      else $error("compare block end without request");
   a_outb_write_lands: assert property (outb_wr |=> reg_addr != MFT_ADDR_OUTB ||
      reg_rdata[7:1] == $past(reg_wdata[7:1])) else $error("action control write lost");
endmodule
`default_nettype wire

// ==== mft_outb_flags_dma_ctrl_tb_top.sv ====
// Bench: timer block and controller end joined by the link, driven over APB.
// Assumes the controller's APB map and a bounded wait for pready.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module mft_outb_flags_dma_ctrl_tb_top
   import mft_pkg::*;
;
   logic ref_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic [31:0] q;
   logic pready;
   logic irq;
   logic pin;
   logic onchip;
   logic swc0;
   logic swc1;
   logic bicap = 1'b0;
   logic [4:0] ev = 5'h00;
   logic [7:0] v;
   logic [3:0] act_pin = 4'b1001;
   int err_count = 0;
   int check_count = 0;

   mft_link_if link ();
   always #20 ref_clk_in = ~ref_clk_in;

   mft_outb_flags_dma_ctrl i_mft_outb_flags_dma_ctrl (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .link(link.dev_mp), .cmp0_match_in(ev[0]), .cmp1_match_in(ev[1]), .cap0_event_in(ev[2]),
      .cap1_event_in(ev[3]), .wrap_event_in(ev[4]), .bicapture_mode_in(bicap),
      .timer_output_two_out(pin), .onchip_event_out(onchip), .sw_capture0_out(swc0),
      .sw_capture1_out(swc1));
   mft_dma_int_host i_mft_dma_int_host (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(),
      .irq_out(irq), .link(link.host_mp));
   mft_link_monitor i_mft_link_monitor (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .reg_sel(link.reg_sel), .reg_wr(link.reg_wr), .reg_addr(link.reg_addr),
      .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata), .int_capture(link.int_capture),
      .int_compare(link.int_compare), .int_wrap(link.int_wrap),
      .dma_cap_req(link.dma_cap_req), .dma_cmp_req(link.dma_cmp_req),
      .dma_ptr(link.dma_ptr), .eob_cap(link.eob_cap), .eob_cmp(link.eob_cmp),
      .swap_toggle(link.swap_toggle));

   task automatic results();
      $display("Checks %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk_in);
      penable <= 1'b1;
      // Ends when pready is seen; the watchdog ends it only if pready never comes
      do begin
         @(posedge ref_clk_in);
      end while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      // Let the write land before anyone samples the outputs
      #1;
   endtask

   // Device registers sit in the window at word index equal to their address
   task automatic dw(input logic [7:0] r, input logic [7:0] d);
      apb(1'b1, {2'b01, r, 2'b00}, {24'h00_0000, d});
   endtask

   task automatic chk_dev(input logic [7:0] r, input logic [7:0] e);
      apb(1'b0, {2'b01, r, 2'b00}, 32'h0000_0000);
      `CHK(q, {24'h00_0000, e})
   endtask

   // Status order is wrap, compare, capture
   task automatic chk_st(input logic [2:0] e);
      apb(1'b0, MFT_APB_STATUS, 32'h0000_0000);
      `CHK({q[18:16], irq}, {e, |e})
   endtask

   task automatic pulse(input logic [4:0] e);
      @(posedge ref_clk_in);
      ev <= e;
      @(posedge ref_clk_in);
      ev <= 5'h00;
      #1;
   endtask

   initial begin
      repeat (5000) @(posedge ref_clk_in);
      err_count++;
      results();
   end

   initial begin
      repeat (5) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      chk_dev(MFT_ADDR_OUTB, MFT_OUTB_RST);
      chk_dev(MFT_ADDR_FLAGS, MFT_FLAGS_RST);
      chk_dev(MFT_ADDR_MASK, MFT_MASK_RST);
      chk_dev(MFT_ADDR_PTR, MFT_PTR_RST);
      chk_dev(8'h00, 8'h00);
      for (int k = 0; k < 3; k++) begin
         for (int c = 0; c < 4; c++) begin
            v = 8'(c << (6 - 2 * k)) | 8'(c != 0);
            dw(MFT_ADDR_OUTB, v);
            `CHK(pin, v[0])
            pulse(k == 2 ? 5'h10 : 5'(1 << k));
            `CHK(pin, act_pin[c])
            chk_dev(MFT_ADDR_OUTB, {v[7:1], act_pin[c]});
         end
      end
      dw(MFT_ADDR_OUTB, 8'h0e);
      pulse(5'h10);
      `CHK({onchip, pin}, 2'b10)
      dw(MFT_ADDR_OUTB, 8'h0c);
      pulse(5'h10);
      `CHK(onchip, 1'b0)
      dw(MFT_ADDR_OUTB, 8'h6c);
      pulse(5'h03);
      `CHK(pin, 1'b1)
      dw(MFT_ADDR_OUTB, 8'h75);
      pulse(5'h11);
      `CHK(pin, 1'b0)
      dw(MFT_ADDR_FLAGS, 8'h00);
      pulse(5'h01);
      pulse(5'h02);
      pulse(5'h10);
      chk_dev(MFT_ADDR_FLAGS, 8'h38);
      dw(MFT_ADDR_MASK, 8'h07);
      chk_st(3'b000);
      dw(MFT_ADDR_MASK, 8'h87);
      chk_st(3'b110);
      dw(MFT_ADDR_FLAGS, 8'h10);
      chk_st(3'b010);
      dw(MFT_ADDR_MASK, 8'h85);
      chk_st(3'b000);
      pulse(5'h01);
      pulse(5'h01);
      chk_dev(MFT_ADDR_FLAGS, 8'h32);
      dw(MFT_ADDR_FLAGS, 8'h80);
      `CHK(swc0, 1'b1)
      chk_dev(MFT_ADDR_FLAGS, 8'h84);
      dw(MFT_ADDR_MASK, 8'ha0);
      dw(MFT_ADDR_FLAGS, 8'h01);
      pulse(5'h04);
      chk_st(3'b000);
      pulse(5'h08);
      chk_st(3'b001);
      chk_dev(MFT_ADDR_FLAGS, 8'hc1);
      dw(MFT_ADDR_FLAGS, 8'h00);
      pulse(5'h04);
      chk_st(3'b001);
      dw(MFT_ADDR_MASK, 8'h08);
      pulse(5'h01);
      chk_dev(MFT_ADDR_MASK, 8'h00);
      chk_dev(MFT_ADDR_PTR, 8'h02);
      apb(1'b1, MFT_APB_CAP_LEN, 32'h0000_0002);
      dw(MFT_ADDR_MASK, 8'h40);
      pulse(5'h04);
      chk_dev(MFT_ADDR_MASK, 8'h40);
      pulse(5'h04);
      chk_dev(MFT_ADDR_MASK, 8'h00);
      dw(MFT_ADDR_PTR, 8'hff);
      chk_dev(MFT_ADDR_PTR, 8'hfd);
      apb(1'b1, MFT_APB_CTRL, 32'h0000_0001);
      dw(MFT_ADDR_MASK, 8'h08);
      pulse(5'h01);
      chk_dev(MFT_ADDR_PTR, 8'hfb);
      // Capture 1 emulation suppressed in bicapture mode
      @(posedge ref_clk_in);
      bicap <= 1'b1;
      dw(MFT_ADDR_FLAGS, 8'h40);
      `CHK({swc1, swc0}, 2'b00)
      chk_dev(MFT_ADDR_FLAGS, 8'h40);
      @(posedge ref_clk_in);
      bicap <= 1'b0;
      dw(MFT_ADDR_FLAGS, 8'h40);
      `CHK({swc1, swc0}, 2'b10)
      results();
   end
endmodule
`default_nettype wire
